//--- bench/tb.sv
// self-checking bench for the command and frame configuration block
`timescale 1ns/100ps
module tb;
	logic clk_in;
	logic reset_in = 1'b1;
	logic [9:0] pv = 10'h000;
	logic [11:0] cv = 12'hc00;
	logic issue;
	logic [3:0] flags = 4'h0;
	logic [3:0] gap = 4'h0;
	logic [7:0] frags = 8'h03;
	logic [3:0] cb_flags;
	logic [12:0] ev = 13'h0000;
	logic clr_req = 1'b0;
	logic clr_ack = 1'b0;
	int fail_count = 0;
	int n_compared = 0;
	logic configure_in, ext_stats_in, std_transmit_command_block_in, cu_idle_irq_mode_in, tx_bad_status_irq_in;
	logic mgmt_controller_stats_in, late_update_in, two_frame_in, dynamic_tbd_in, short_discard_in;
	logic keep_bad_frames_in, cb_done_in, cb_end_of_list_bit_in, cb_suspend_in, cb_irq_req_in, cb_is_tx_in;
	logic next_cb_start_in, tx_bad_done_in, tbd_fetch_in, tx_frame_push_in, tx_frame_pop_in, tx_start_in;
	logic tx_underrun_in, rx_byte_in, rx_frame_end_in;
	logic [1:0] underrun_retry_in;
	logic tbd_pointer_ok_in = 1'b0;
	logic tbd_end_of_list_bit_in = 1'b0;
	logic [7:0] tbd_index_in = 8'h00;
	logic [7:0] tbd_count_in;
	logic [11:0] tx_fifo_bytes_in = 12'h000;
	logic tx_whole_frame_in = 1'b0;
	logic rx_frame_bad_in = 1'b0;
	logic [11:0] header_data_size_in = 12'h010;
	logic [7:0] stats_counters_out, stats_bytes_out;
	logic [3:0] cb_fetch_dwords_out;
	logic [1:0] cu_state_out;
	logic stats_reserved_out, transmit_command_block_extended_out, cmd_complete_flag_out, cu_left_active_irq_out, cu_idle_irq_out;
	logic scb_write_out, irq_out, tx_fifo_accept_out, tbd_last_out, tbd_invalid_out, tx_retry_go_out;
	logic tx_failed_out, underrun_count_out, rx_write_enable_out, rx_bad_status_out, rx_discard_out;
	logic rx_reuse_descriptor_out;
	logic [23:0] st [4] = '{24'h001350, 24'h001044, 24'h010000, 24'h001560};
	assign {issue, rx_frame_end_in, rx_byte_in, tx_underrun_in, tx_start_in, tx_frame_pop_in, tx_frame_push_in,
		tbd_fetch_in, tx_bad_done_in, configure_in} = pv;
	assign {ext_stats_in, std_transmit_command_block_in, cu_idle_irq_mode_in, tx_bad_status_irq_in, mgmt_controller_stats_in,
		late_update_in, two_frame_in, dynamic_tbd_in, underrun_retry_in, short_discard_in, keep_bad_frames_in} = cv;
	assign {cb_end_of_list_bit_in, cb_suspend_in, cb_irq_req_in, cb_is_tx_in} = cb_flags;
	txrxc_top dut_u (.*);
	txrxc_host host_u (.clk_in(clk_in), .reset_in(reset_in), .issue_in(issue), .flags_in(flags), .gap_in(gap),
		.dynamic_in(dynamic_tbd_in), .frags_in(frags), .next_cb_start_out(next_cb_start_in),
		.cb_done_out(cb_done_in), .cb_flags_out(cb_flags), .tbd_count_out(tbd_count_in));
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// pulses are one cycle wide, so they are collected here; a toggle of clr_req empties the collector
	always @(posedge clk_in) begin
		clr_ack <= clr_req;
		ev <= (clr_req != clr_ack ? 13'h0000 : ev) | {rx_bad_status_out, rx_reuse_descriptor_out, rx_discard_out,
			underrun_count_out, tx_failed_out,
			tx_retry_go_out, tbd_invalid_out, tbd_last_out, cmd_complete_flag_out, cu_idle_irq_out,
			cu_left_active_irq_out, irq_out, scb_write_out};
	end
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic evchk(input logic [12:0] m, input logic [12:0] e);
		chk(ev & m, e);
		clr_req = ~clr_req;
	endtask : evchk
	task automatic wait_see(input int n);
		repeat (n) @(posedge clk_in);
		@(negedge clk_in);
	endtask : wait_see
	task automatic pulse(input logic [9:0] m, input int n);
		@(posedge clk_in);
		pv <= m;
		repeat (n) @(posedge clk_in);
		pv <= 10'h000;
	endtask : pulse
	task automatic conf(input logic [11:0] c);
		@(posedge clk_in);
		cv <= c;
		pulse(10'h001, 1);
		wait_see(3);
		clr_req = ~clr_req;
	endtask : conf
	task automatic run_cb(input logic [3:0] f);
		int k;
		k = 0;
		flags <= f;
		pulse(10'h200, 1);
		do begin
			@(negedge clk_in);
			k++;
		end while (cb_done_in !== 1'b1 && k < 40);
		if (k == 40) begin
			fail_count++;
			close_out();
		end
		// the completion pulses show one edge after done and reach the collector one edge later
		wait_see(2);
	endtask : run_cb
	task automatic transmit_buffer_descriptor(input logic ok, input logic endb, input logic [7:0] idx, input logic [1:0] e);
		@(posedge clk_in);
		tbd_pointer_ok_in <= ok;
		tbd_end_of_list_bit_in <= endb;
		tbd_index_in <= idx;
		pulse(10'h004, 1);
		wait_see(2);
		evchk(13'h0060, {6'h00, e, 5'h00});
	endtask : transmit_buffer_descriptor
	// go must hold off while only lo is buffered, then follow hi or the whole frame
	task automatic att(input logic [11:0] lo, input logic [11:0] hi, input logic wh);
		@(posedge clk_in);
		tx_fifo_bytes_in <= lo;
		tx_whole_frame_in <= 1'b0;
		pulse(10'h040, 1);
		wait_see(4);
		evchk(13'h0080, 13'h0000);
		@(posedge clk_in);
		tx_fifo_bytes_in <= hi;
		tx_whole_frame_in <= wh;
		wait_see(4);
		evchk(13'h0380, 13'h0080);
		@(posedge clk_in);
		tx_fifo_bytes_in <= 12'h000;
		tx_whole_frame_in <= 1'b0;
	endtask : att
	task automatic rx(input int n, input logic bad, input logic we, input logic [12:0] e);
		@(posedge clk_in);
		rx_frame_bad_in <= bad;
		pulse(10'h080, n);
		wait_see(2);
		chk(rx_write_enable_out, we);
		pulse(10'h100, 1);
		wait_see(2);
		evchk(13'h1c00, e);
	endtask : rx
	initial begin
		repeat (10) @(posedge clk_in);
		reset_in <= 1'b0;
		wait_see(2);
		chk({stats_reserved_out, stats_counters_out, stats_bytes_out}, 24'h001044);
		chk({cb_fetch_dwords_out, tx_fifo_accept_out}, 24'h000009);
		for (int i = 0; i < 4; i++) begin
			conf({i[0], i[0], 2'h0, i[1], 7'h00});
			chk({stats_reserved_out, stats_counters_out, stats_bytes_out}, st[i]);
			chk({transmit_command_block_extended_out, cb_fetch_dwords_out}, i[0] ? 24'h000004 : 24'h000018);
		end
		conf(12'hc00);
		run_cb(4'h8);
		evchk(13'h000f, 13'h0007);
		chk(cu_state_out, 24'h000000);
		run_cb(4'h4);
		evchk(13'h000c, 13'h0004);
		chk(cu_state_out, 24'h000002);
		conf(12'he00);
		run_cb(4'h4);
		evchk(13'h000e, 13'h0000);
		run_cb(4'h6);
		evchk(13'h0002, 13'h0002);
		run_cb(4'h8);
		evchk(13'h000c, 13'h0008);
		conf(12'hc40);
		gap <= 4'h5;
		run_cb(4'h8);
		evchk(13'h0001, 13'h0000);
		run_cb(4'h8);
		evchk(13'h0001, 13'h0001);
		for (int b = 0; b < 2; b++) begin
			conf(b[0] ? 12'hd00 : 12'hc00);
			pulse(10'h002, 1);
			wait_see(2);
			evchk(13'h0012, b[0] ? 13'h0012 : 13'h0000);
		end
		run_cb(4'hb);
		evchk(13'h0010, 13'h0010);
		conf(12'hc20);
		pulse(10'h008, 3);
		wait_see(2);
		chk(tx_fifo_accept_out, 24'h000000);
		pulse(10'h010, 2);
		wait_see(2);
		chk(tx_fifo_accept_out, 24'h000001);
		conf(12'hc00);
		transmit_buffer_descriptor(1'b0, 1'b1, 8'h00, 2'h0);
		transmit_buffer_descriptor(1'b1, 1'b0, 8'h02, 2'h1);
		conf(12'hc10);
		transmit_buffer_descriptor(1'b0, 1'b0, 8'h00, 2'h2);
		transmit_buffer_descriptor(1'b1, 1'b1, 8'h00, 2'h1);
		conf(12'hc00);
		pulse(10'h020, 1);
		pulse(10'h040, 1);
		wait_see(3);
		evchk(13'h0380, 13'h0300);
		conf(12'hc04);
		pulse(10'h020, 1);
		att(12'hfff, 12'h000, 1'b1);
		conf(12'hc08);
		pulse(10'h020, 1);
		att(12'h1ff, 12'h200, 1'b0);
		att(12'hfff, 12'h000, 1'b1);
		conf(12'hc0c);
		pulse(10'h020, 1);
		att(12'h1ff, 12'h200, 1'b0);
		att(12'h3ff, 12'h400, 1'b0);
		att(12'hfff, 12'h000, 1'b1);
		conf(12'hc02);
		rx(10, 1'b0, 1'b0, 13'h0c00);
		rx(70, 1'b0, 1'b1, 13'h0000);
		conf(12'hc00);
		rx(20, 1'b0, 1'b1, 13'h1000);
		rx(70, 1'b1, 1'b1, 13'h0c00);
		conf(12'hc01);
		rx(70, 1'b1, 1'b1, 13'h1000);
		close_out();
	end
endmodule : tb

//--- bench/txrxc_host.sv
// host driver model: issues command blocks and fills descriptor counts
`timescale 1ns/100ps
module txrxc_host (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic issue_in,
	input wire logic [3:0] flags_in,
	input wire logic [3:0] gap_in,
	input wire logic dynamic_in,
	input wire logic [7:0] frags_in,
	output logic next_cb_start_out,
	output logic cb_done_out,
	output logic [3:0] cb_flags_out,
	output logic [7:0] tbd_count_out
);
	logic [4:0] wait_count;
	logic [3:0] held;
	assign tbd_count_out = dynamic_in ? 8'hff : frags_in;
	// flags mean nothing outside the done pulse, so they show the inverse there
	assign cb_flags_out = cb_done_out ? held : ~held;
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			next_cb_start_out <= 1'b0;
			cb_done_out <= 1'b0;
			wait_count <= 5'h00;
			held <= 4'h0;
		end else begin
			next_cb_start_out <= issue_in;
			cb_done_out <= (wait_count == 5'h01);
			if (issue_in) begin
				held <= flags_in;
				wait_count <= {1'b0, gap_in} + 5'h02;
			end else if (wait_count != 5'h00) begin
				wait_count <= wait_count - 5'h01;
			end
		end
	end
endmodule : txrxc_host

//--- bench/txrxc_properties.sv
// concurrent checks on the command and frame configuration block ports
`timescale 1ns/100ps
module txrxc_properties (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic configure_in,
	input wire logic ext_stats_in,
	input wire logic std_transmit_command_block_in,
	input wire logic mgmt_controller_stats_in,
	input wire logic cb_done_in,
	input wire logic cb_end_of_list_bit_in,
	input wire logic tbd_fetch_in,
	input wire logic tbd_pointer_ok_in,
	input wire logic [11:0] tx_fifo_bytes_in,
	input wire logic tx_whole_frame_in,
	input wire logic tx_underrun_in,
	input wire logic [7:0] stats_counters_out,
	input wire logic [7:0] stats_bytes_out,
	input wire logic [3:0] cb_fetch_dwords_out,
	input wire logic transmit_command_block_extended_out,
	input wire logic [1:0] cu_state_out,
	input wire logic cu_left_active_irq_out,
	input wire logic cu_idle_irq_out,
	input wire logic irq_out,
	input wire logic tbd_invalid_out,
	input wire logic tx_retry_go_out,
	input wire logic tx_failed_out,
	input wire logic underrun_count_out
);
	default clocking dc @(posedge clk_in);
	endclocking
	default disable iff (reset_in);
	// configure lands one edge later, the layout register one edge after that
	property p_mgmt_stats;
		configure_in && mgmt_controller_stats_in && ext_stats_in |-> ##2 stats_counters_out == 8'h15 && stats_bytes_out == 8'h60;
	endproperty
	a_mgmt_stats: assert property (p_mgmt_stats) else $error("statistics layout wrong");
	property p_ext_fetch;
		configure_in && !std_transmit_command_block_in |-> ##2 cb_fetch_dwords_out == 4'h8 && transmit_command_block_extended_out;
	endproperty
	a_ext_fetch: assert property (p_ext_fetch) else $error("extended block fetch wrong");
	property p_end_idle;
		cb_done_in && cb_end_of_list_bit_in && cu_state_out == 2'h1 |=> cu_state_out == 2'h0;
	endproperty
	a_end_idle: assert property (p_end_idle) else $error("command unit not idle after end of list");
	property p_idle_irq;
		cu_idle_irq_out |-> cu_state_out == 2'h0 && $past(cu_state_out) == 2'h1 && irq_out;
	endproperty
	a_idle_irq: assert property (p_idle_irq) else $error("idle interrupt without idle entry");
	property p_left_active;
		cu_left_active_irq_out |-> $past(cb_done_in) && $past(cu_state_out) == 2'h1 && cu_state_out != 2'h1;
	endproperty
	a_left_active: assert property (p_left_active) else $error("left active interrupt without cause");
	property p_fail;
		tx_failed_out |-> underrun_count_out && !tx_retry_go_out && $past(tx_underrun_in, 2);
	endproperty
	a_fail: assert property (p_fail) else $error("failed frame not counted");
	// retry may only launch two edges after enough data or the whole frame was present
	property p_go;
		tx_retry_go_out |-> $past(tx_whole_frame_in, 2) || $past(tx_fifo_bytes_in, 2) >= 12'h200;
	endproperty
	a_go: assert property (p_go) else $error("retry launched too early");
	property p_invalid;
		tbd_invalid_out |-> $past(tbd_fetch_in) && !$past(tbd_pointer_ok_in);
	endproperty
	a_invalid: assert property (p_invalid) else $error("descriptor flagged invalid without cause");
endmodule : txrxc_properties
bind txrxc_top txrxc_properties chk_u (.*);

//--- core/txrxc_cfg_if.sv
// retry mode and transmit status carried from the main block to the underrun retry engine, go, fail and done back
`timescale 1ns/100ps
interface txrxc_cfg_if;
	logic [1:0] retry_mode;
	logic tx_start;
	logic tx_underrun;
	logic [11:0] fifo_bytes;
	logic whole_frame;
	logic go;
	logic fail;
	logic done;
	modport main (output retry_mode, tx_start, tx_underrun, fifo_bytes, whole_frame, input go, fail, done);
	modport retry (input retry_mode, tx_start, tx_underrun, fifo_bytes, whole_frame, output go, fail, done);
endinterface : txrxc_cfg_if

//--- core/txrxc_defines.svh
// size, field and reset constants for the command and frame configuration block
`ifndef TXRXC_DEFINES_SVH
`define TXRXC_DEFINES_SVH
`define TXRXC_STATS_STD_COUNT 8'h10
`define TXRXC_STATS_STD_BYTES 8'h44
`define TXRXC_STATS_FULL_COUNT 8'h13
`define TXRXC_STATS_FULL_BYTES 8'h50
`define TXRXC_STATS_MGMT_COUNT 8'h15
`define TXRXC_STATS_MGMT_BYTES 8'h60
`define TXRXC_TRANSMIT_COMMAND_BLOCK_STD_DWORDS 4'h4
`define TXRXC_TRANSMIT_COMMAND_BLOCK_EXT_DWORDS 4'h8
`define TXRXC_RETRY_FIRST_BYTES 12'h200
`define TXRXC_RETRY_SECOND_BYTES 12'h400
`define TXRXC_SHORT_FRAME_BYTES 12'h040
`define TXRXC_TBD_COUNT_ALL_ONES 8'hff
`define TXRXC_FIFO_FRAME_LIMIT 2'h2
`define TXRXC_RST_EXT_STATS 1'b1
`define TXRXC_RST_STD_TRANSMIT_COMMAND_BLOCK 1'b1
`endif

//--- core/txrxc_pkg.sv
// types shared by the command and frame configuration block
package txrxc_pkg;
	typedef enum logic [1:0] {
		TXRXC_RETRY_NONE,
		TXRXC_RETRY_ONE,
		TXRXC_RETRY_TWO,
		TXRXC_RETRY_THREE
	} txrxc_retry_t;
	typedef enum logic [1:0] {
		TXRXC_STATS_STD,
		TXRXC_STATS_FULL,
		TXRXC_STATS_MGMT,
		TXRXC_STATS_RSVD
	} txrxc_stats_t;
endpackage : txrxc_pkg

//--- core/txrxc_retry.sv
// underrun retransmission policy engine
`timescale 1ns/100ps
`include "txrxc_defines.svh"
module txrxc_retry (
	input wire logic clk_in,
	input wire logic reset_in,
	txrxc_cfg_if.retry cfg
);
	import txrxc_pkg::*;
	logic [1:0] attempts;
	logic waiting;
	logic [11:0] threshold;
	always_comb begin
		threshold = 12'hfff;
		if (cfg.retry_mode == 2'h2 && attempts == 2'h1) begin
			threshold = `TXRXC_RETRY_FIRST_BYTES;
		end else if (cfg.retry_mode == 2'h3 && attempts == 2'h1) begin
			threshold = `TXRXC_RETRY_FIRST_BYTES;
		end else if (cfg.retry_mode == 2'h3 && attempts == 2'h2) begin
			threshold = `TXRXC_RETRY_SECOND_BYTES;
		end
	end
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			attempts <= 2'h0;
			waiting <= 1'b0;
			cfg.go <= 1'b0;
			cfg.fail <= 1'b0;
			cfg.done <= 1'b0;
		end else begin
			cfg.go <= 1'b0;
			cfg.fail <= 1'b0;
			cfg.done <= 1'b0;
			if (cfg.tx_start && !waiting) begin
				attempts <= 2'h0;
			end
			if (cfg.tx_underrun) begin
				if (attempts >= cfg.retry_mode) begin
					cfg.fail <= 1'b1;
					waiting <= 1'b0;
					attempts <= 2'h0;
				end else begin
					attempts <= attempts + 2'h1;
					waiting <= 1'b1;
				end
			end else if (waiting) begin
				// last permitted retry waits for the full frame so it cannot underrun again
				if (cfg.whole_frame || (attempts != cfg.retry_mode && cfg.fifo_bytes >= threshold)) begin
					cfg.go <= 1'b1;
					waiting <= 1'b0;
				end
			end
		end
	end
endmodule : txrxc_retry

//--- core/txrxc_top.sv
// command unit and frame engine configuration behaviour
// Summary of operation
// - extended stats bit picks 16/68 or 19/80
// - format bit picks 4 or 8 dword blocks
// - mode 0 interrupts on leaving active
// - mode 1 interrupts entering idle, not on suspend
// - end-of-list idles, suspend bit suspends
// - idle mode still honours per-block interrupt bit
// - bad transmit raises complete flag, interrupt
// - bad-transmit mode keeps per-block interrupt
// - mgmt and extended bits select stats layout
// - late bit defers status write past start
// - two-frame limit caps fifo frames
// - dynamic checking tests pointer and end bit
// - retry 00 fails and counts underrun
// - retry 01 resends with whole frame
// - retry 10 at 512, then whole
// - retry 11 at 512, 1024, whole
// - short-frame discard drops under 64 bytes
// - discard holds receive writes until 64
// - no discard may report short bad status
// - unsaved bad frames reuse receive descriptor
`timescale 1ns/100ps
`include "txrxc_defines.svh"
module txrxc_top (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic configure_in,
	input wire logic ext_stats_in,
	input wire logic std_transmit_command_block_in,
	input wire logic cu_idle_irq_mode_in,
	input wire logic tx_bad_status_irq_in,
	input wire logic mgmt_controller_stats_in,
	input wire logic late_update_in,
	input wire logic two_frame_in,
	input wire logic dynamic_tbd_in,
	input wire logic [1:0] underrun_retry_in,
	input wire logic short_discard_in,
	input wire logic keep_bad_frames_in,
	input wire logic cb_done_in,
	input wire logic cb_end_of_list_bit_in,
	input wire logic cb_suspend_in,
	input wire logic cb_irq_req_in,
	input wire logic cb_is_tx_in,
	input wire logic next_cb_start_in,
	input wire logic tx_bad_done_in,
	input wire logic tbd_fetch_in,
	input wire logic tbd_pointer_ok_in,
	input wire logic tbd_end_of_list_bit_in,
	input wire logic [7:0] tbd_index_in,
	input wire logic [7:0] tbd_count_in,
	input wire logic tx_frame_push_in,
	input wire logic tx_frame_pop_in,
	input wire logic tx_start_in,
	input wire logic tx_underrun_in,
	input wire logic [11:0] tx_fifo_bytes_in,
	input wire logic tx_whole_frame_in,
	input wire logic rx_byte_in,
	input wire logic rx_frame_end_in,
	input wire logic rx_frame_bad_in,
	input wire logic [11:0] header_data_size_in,
	output logic [7:0] stats_counters_out,
	output logic [7:0] stats_bytes_out,
	output logic stats_reserved_out,
	output logic [3:0] cb_fetch_dwords_out,
	output logic transmit_command_block_extended_out,
	output logic [1:0] cu_state_out,
	output logic cmd_complete_flag_out,
	output logic cu_left_active_irq_out,
	output logic cu_idle_irq_out,
	output logic scb_write_out,
	output logic irq_out,
	output logic tx_fifo_accept_out,
	output logic tbd_last_out,
	output logic tbd_invalid_out,
	output logic tx_retry_go_out,
	output logic tx_failed_out,
	output logic underrun_count_out,
	output logic rx_write_enable_out,
	output logic rx_bad_status_out,
	output logic rx_discard_out,
	output logic rx_reuse_descriptor_out
);
	import txrxc_pkg::*;
	typedef enum logic [1:0] {TXRXC_CU_IDLE, TXRXC_CU_ACTIVE, TXRXC_CU_SUSPENDED} txrxc_cu_t;

	logic c_ext_stats;
	logic c_std_transmit_command_block;
	logic c_ci_mode;
	logic c_tx_bad_irq;
	logic c_mgmt_stats;
	logic c_late;
	logic c_two_frame;
	logic c_dyn_tbd;
	logic [1:0] c_retry;
	logic c_short_discard;
	logic c_keep_bad;
	txrxc_cu_t cu_state;
	logic pending;
	logic [1:0] fifo_frames;
	logic [11:0] rx_count;
	logic rx_header_written;
	txrxc_stats_t stats_mode;
	txrxc_cfg_if rif ();

	function automatic txrxc_stats_t stats_select(input logic mgmt, input logic ext);
		stats_select = mgmt ? (ext ? TXRXC_STATS_MGMT : TXRXC_STATS_RSVD) : (ext ? TXRXC_STATS_STD : TXRXC_STATS_FULL);
	endfunction : stats_select

	// configuration latched on configure and held until the next one
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			c_ext_stats <= `TXRXC_RST_EXT_STATS;
			c_std_transmit_command_block <= `TXRXC_RST_STD_TRANSMIT_COMMAND_BLOCK;
			c_ci_mode <= 1'b0;
			c_tx_bad_irq <= 1'b0;
			c_mgmt_stats <= 1'b0;
			c_late <= 1'b0;
			c_two_frame <= 1'b0;
			c_dyn_tbd <= 1'b0;
			c_retry <= 2'h0;
			c_short_discard <= 1'b0;
			c_keep_bad <= 1'b0;
		end else if (configure_in) begin
			c_ext_stats <= ext_stats_in;
			c_std_transmit_command_block <= std_transmit_command_block_in;
			c_ci_mode <= cu_idle_irq_mode_in;
			c_tx_bad_irq <= tx_bad_status_irq_in;
			c_mgmt_stats <= mgmt_controller_stats_in;
			c_late <= late_update_in;
			c_two_frame <= two_frame_in;
			c_dyn_tbd <= dynamic_tbd_in;
			c_retry <= underrun_retry_in;
			c_short_discard <= short_discard_in;
			c_keep_bad <= keep_bad_frames_in;
		end
	end

	assign stats_mode = stats_select(c_mgmt_stats, c_ext_stats);

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			stats_counters_out <= 8'h00;
			stats_bytes_out <= 8'h00;
			stats_reserved_out <= 1'b0;
			cb_fetch_dwords_out <= 4'h0;
			transmit_command_block_extended_out <= 1'b0;
		end else begin
			stats_reserved_out <= (stats_mode == TXRXC_STATS_RSVD);
			case (stats_mode)
				TXRXC_STATS_STD: begin
					stats_counters_out <= `TXRXC_STATS_STD_COUNT;
					stats_bytes_out <= `TXRXC_STATS_STD_BYTES;
				end
				TXRXC_STATS_FULL: begin
					stats_counters_out <= `TXRXC_STATS_FULL_COUNT;
					stats_bytes_out <= `TXRXC_STATS_FULL_BYTES;
				end
				TXRXC_STATS_MGMT: begin
					stats_counters_out <= `TXRXC_STATS_MGMT_COUNT;
					stats_bytes_out <= `TXRXC_STATS_MGMT_BYTES;
				end
				default: begin
					stats_counters_out <= 8'h00;
					stats_bytes_out <= 8'h00;
				end
			endcase
			cb_fetch_dwords_out <= c_std_transmit_command_block ? `TXRXC_TRANSMIT_COMMAND_BLOCK_STD_DWORDS : `TXRXC_TRANSMIT_COMMAND_BLOCK_EXT_DWORDS;
			transmit_command_block_extended_out <= !c_std_transmit_command_block;
		end
	end

	// command unit state; a done with neither bit keeps the unit active
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			cu_state <= TXRXC_CU_IDLE;
		end else begin
			case (cu_state)
				TXRXC_CU_IDLE, TXRXC_CU_SUSPENDED: begin
					if (next_cb_start_in) begin
						cu_state <= TXRXC_CU_ACTIVE;
					end
				end
				TXRXC_CU_ACTIVE: begin
					if (cb_done_in && cb_end_of_list_bit_in) begin
						cu_state <= TXRXC_CU_IDLE;
					end else if (cb_done_in && cb_suspend_in) begin
						cu_state <= TXRXC_CU_SUSPENDED;
					end
				end
				default: cu_state <= TXRXC_CU_IDLE;
			endcase
		end
	end
	assign cu_state_out = cu_state;

	// interrupt events; with late update the status write waits for the next start
	logic leave_idle;
	logic leave_susp;
	logic ev_cx;
	logic ev_cna;
	logic ev_ci;
	logic ev_any;
	assign leave_idle = cu_state == TXRXC_CU_ACTIVE && cb_done_in && cb_end_of_list_bit_in;
	assign leave_susp = cu_state == TXRXC_CU_ACTIVE && cb_done_in && !cb_end_of_list_bit_in && cb_suspend_in;
	assign ev_cx = (cb_done_in && cb_irq_req_in) || (c_tx_bad_irq && tx_bad_done_in);
	assign ev_cna = !c_ci_mode && (leave_idle || leave_susp);
	assign ev_ci = c_ci_mode && leave_idle;
	assign ev_any = ev_cx || ev_cna || ev_ci;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			cmd_complete_flag_out <= 1'b0;
			cu_left_active_irq_out <= 1'b0;
			cu_idle_irq_out <= 1'b0;
			pending <= 1'b0;
			scb_write_out <= 1'b0;
			irq_out <= 1'b0;
		end else begin
			cmd_complete_flag_out <= ev_cx;
			cu_left_active_irq_out <= ev_cna;
			cu_idle_irq_out <= ev_ci;
			irq_out <= ev_any;
			if (!c_late) begin
				scb_write_out <= ev_any;
				pending <= 1'b0;
			end else begin
				scb_write_out <= pending && next_cb_start_in;
				// a new event arriving with the start is kept, set wins over clear
				pending <= ev_any || (pending && !next_cb_start_in);
			end
		end
	end

	// transmit fifo frame count for the two-frame limit
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			fifo_frames <= 2'h0;
			tx_fifo_accept_out <= 1'b0;
		end else begin
			if (tx_frame_push_in && tx_fifo_accept_out && !tx_frame_pop_in && fifo_frames != 2'h3) begin
				fifo_frames <= fifo_frames + 2'h1;
			end else if (tx_frame_pop_in && !(tx_frame_push_in && tx_fifo_accept_out) && fifo_frames != 2'h0) begin
				fifo_frames <= fifo_frames - 2'h1;
			end
			tx_fifo_accept_out <= !c_two_frame || ({1'b0, fifo_frames} + {2'h0, tx_frame_push_in}
				< {1'b0, `TXRXC_FIFO_FRAME_LIMIT});
		end
	end

	// descriptor checking; with dynamic mode the host sets count all ones, but only the end bit and pointer are checked
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			tbd_last_out <= 1'b0;
			tbd_invalid_out <= 1'b0;
		end else begin
			tbd_last_out <= 1'b0;
			tbd_invalid_out <= 1'b0;
			if (tbd_fetch_in) begin
				if (c_dyn_tbd) begin
					tbd_last_out <= tbd_end_of_list_bit_in;
					tbd_invalid_out <= !tbd_pointer_ok_in;
				end else begin
					tbd_last_out <= tbd_index_in + 8'h01 == tbd_count_in;
				end
			end
		end
	end

	assign rif.retry_mode = c_retry;
	assign rif.tx_start = tx_start_in;
	assign rif.tx_underrun = tx_underrun_in;
	assign rif.fifo_bytes = tx_fifo_bytes_in;
	assign rif.whole_frame = tx_whole_frame_in;
	txrxc_retry u_retry (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.cfg(rif)
	);
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			tx_retry_go_out <= 1'b0;
			tx_failed_out <= 1'b0;
			underrun_count_out <= 1'b0;
		end else begin
			tx_retry_go_out <= rif.go;
			tx_failed_out <= rif.fail;
			underrun_count_out <= rif.fail;
		end
	end

	// receive side: short frame discard and descriptor reuse
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rx_count <= 12'h000;
			rx_header_written <= 1'b0;
			rx_write_enable_out <= 1'b0;
			rx_bad_status_out <= 1'b0;
			rx_discard_out <= 1'b0;
			rx_reuse_descriptor_out <= 1'b0;
		end else begin
			rx_bad_status_out <= 1'b0;
			rx_discard_out <= 1'b0;
			rx_reuse_descriptor_out <= 1'b0;
			if (rx_frame_end_in) begin
				rx_count <= 12'h000;
				rx_header_written <= 1'b0;
				rx_write_enable_out <= 1'b0;
				if (rx_count < `TXRXC_SHORT_FRAME_BYTES && c_short_discard) begin
					rx_discard_out <= 1'b1;
					rx_reuse_descriptor_out <= 1'b1;
				end else if (rx_frame_bad_in || rx_count < `TXRXC_SHORT_FRAME_BYTES) begin
					// a short frame's descriptor whose header area was filled cannot be taken back
					if (rx_header_written && rx_count < `TXRXC_SHORT_FRAME_BYTES) begin
						rx_bad_status_out <= 1'b1;
					end else if (!c_keep_bad) begin
						rx_discard_out <= 1'b1;
						rx_reuse_descriptor_out <= 1'b1;
					end else begin
						rx_bad_status_out <= 1'b1;
					end
				end
			end else if (rx_byte_in) begin
				if (rx_count != 12'hfff) begin
					rx_count <= rx_count + 12'h001;
				end
				if (!c_short_discard && rx_count + 12'h001 >= header_data_size_in) begin
					rx_header_written <= 1'b1;
				end
				rx_write_enable_out <= !c_short_discard || rx_count + 12'h001 >= `TXRXC_SHORT_FRAME_BYTES;
			end
		end
	end
endmodule : txrxc_top
